// file: hdl/wakeup_irq_pkg.sv
// Constants for the wake-up and interrupt dispatch block.
// Assumes one 200 MHz core clock and a plain byte register port.
package wakeup_irq_pkg;
	localparam int DW = 8;
	localparam int AW = 3;
	localparam int NSRC = 7;
	localparam logic [DW-1:0] RST_BYTE = 8'h00;
	// Register offsets
	localparam logic [AW-1:0] ADDR_IRQ_EN  = 3'h0;
	localparam logic [AW-1:0] ADDR_IRQ_FLG = 3'h1;
	localparam logic [AW-1:0] ADDR_WAKE    = 3'h2;
	localparam logic [AW-1:0] ADDR_LVD     = 3'h3;
	localparam logic [AW-1:0] ADDR_ADC     = 3'h4;
	localparam logic [AW-1:0] ADDR_STATUS  = 3'h5;
	// Enable and flag byte layout
	localparam int BIT_EXT  = 2;
	localparam int BIT_ADC  = 3;
	localparam int BIT_PWM1 = 4;
	localparam int BIT_CMP  = 7;
	// Wake control byte layout
	localparam int WBIT_CMP = 2;
	localparam int WBIT_ADC = 3;
	localparam int WBIT_WDT = 7;
	// Low-voltage byte layout
	localparam int LBIT_WAKE = 3;
	localparam int LBIT_IE   = 4;
	localparam int LBIT_FLAG = 5;
	// Converter control and status layout
	localparam int ABIT_RUN   = 0;
	localparam int SBIT_GIE   = 0;
	localparam int SBIT_SLEEP = 1;
	// Internal source order, also the priority order
	localparam int SRC_EXT  = 0;
	localparam int SRC_ADC  = 1;
	localparam int SRC_PWM1 = 2;
	localparam int SRC_CMP  = 5;
	localparam int SRC_LVD  = 6;
	// Program addresses
	localparam logic [DW-1:0] VEC_RESET = 8'h00;
	localparam logic [DW-1:0] VEC_EXT   = 8'h03;
	localparam logic [DW-1:0] VEC_ADC   = 8'h0C;
	localparam logic [DW-1:0] VEC_PWM1  = 8'h12;
	localparam logic [DW-1:0] VEC_PWM2  = 8'h15;
	localparam logic [DW-1:0] VEC_PWM3  = 8'h18;
	localparam logic [DW-1:0] VEC_LVD   = 8'h1B;
	typedef enum logic {
		MODE_RUN   = 1'b0,
		MODE_SLEEP = 1'b1
	} mode_e;
endpackage : wakeup_irq_pkg

// file: hdl/wakeup_interrupt_dispatch.sv
// Wake-up and interrupt dispatch for an 8-bit core.
// Assumes same-clock event pulses from peripherals and the core,
// and raw asynchronous pin, comparator and detector levels.
`timescale 1ns/1ps

module wakeup_interrupt_dispatch
	import wakeup_irq_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire logic          resetn,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          wr_en,
	input  wire logic          rd_en,
	output logic      [DW-1:0] rd_data,
	input  wire logic          ext_pin,
	input  wire logic          cmp_out,
	input  wire logic          low_volt_detect,
	input  wire logic          adc_done,
	input  wire logic [2:0]    pwm_match,
	input  wire logic          wdt_timeout,
	input  wire logic          sleep_req,
	input  wire logic          global_irq_enable_instr,
	input  wire logic          global_irq_disable_instr,
	input  wire logic          irq_ack,
	output logic               irq_req,
	output logic      [DW-1:0] irq_vector,
	output logic               wake_pulse,
	output logic               asleep,
	output logic               osc_run,
	output logic               adc_running,
	output logic               wdt_reset
);

	typedef struct packed {
		mode_e           mode;
		logic            gie;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] flag;
		logic            cmp_wake;
		logic            adc_wake;
		logic            lvd_wake;
		logic            wdt_en;
		logic            adc_run;
		logic [2:0]      ext_s;
		logic [2:0]      cmp_s;
		logic [2:0]      lvd_s;
		logic            irq_req;
		logic [DW-1:0]   vec;
		logic            wake;
		logic            osc;
		logic            wdt_rst;
		logic [DW-1:0]   rd;
	} state_s;

	state_s          state_reg;
	state_s          state_next;
	logic [NSRC-1:0] ev;
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] wakeable;
	logic            wake_ev;

	// Byte enable/flag layout to internal source order
	function automatic logic [NSRC-1:0] to_src(
		input logic [DW-1:0] b,
		input logic          lvd
	);
		to_src = {lvd, b[BIT_CMP], b[BIT_PWM1+:3], b[BIT_ADC],
			b[BIT_EXT]};
	endfunction : to_src

	function automatic logic [DW-1:0] to_byte(
		input logic [NSRC-1:0] s
	);
		to_byte = RST_BYTE;
		to_byte[BIT_EXT] = s[SRC_EXT];
		to_byte[BIT_ADC] = s[SRC_ADC];
		to_byte[BIT_PWM1+:3] = s[SRC_PWM1+:3];
		to_byte[BIT_CMP] = s[SRC_CMP];
	endfunction : to_byte

	// Lowest index wins; comparator shares the first PWM address
	function automatic logic [DW-1:0] pick_vec(
		input logic [NSRC-1:0] p
	);
		if (p[SRC_EXT])
			pick_vec = VEC_EXT;
		else if (p[SRC_ADC])
			pick_vec = VEC_ADC;
		else if (p[SRC_PWM1])
			pick_vec = VEC_PWM1;
		else if (p[SRC_PWM1+1])
			pick_vec = VEC_PWM2;
		else if (p[SRC_PWM1+2])
			pick_vec = VEC_PWM3;
		else if (p[SRC_CMP])
			pick_vec = VEC_PWM1;
		else
			pick_vec = VEC_LVD;
	endfunction : pick_vec

	always_comb begin
		state_next = state_reg;
		// Only stage two and three of each synchroniser are read
		state_next.ext_s = {state_reg.ext_s[1:0], ext_pin};
		state_next.cmp_s = {state_reg.cmp_s[1:0], cmp_out};
		state_next.lvd_s = {state_reg.lvd_s[1:0], low_volt_detect};

		ev = '0;
		// Pin interrupt is not a sleep source; falling edge
		ev[SRC_EXT] = state_reg.ext_s[2] & ~state_reg.ext_s[1]
			& (state_reg.mode == MODE_RUN);
		// Done only counts while the converter is running
		ev[SRC_ADC] = adc_done & state_reg.adc_run;
		// Timers are stopped in sleep, so matches are dropped
		ev[SRC_PWM1+:3] = pwm_match
			& {3{state_reg.mode == MODE_RUN}};
		ev[SRC_CMP] = state_reg.cmp_s[2] ^ state_reg.cmp_s[1];
		ev[SRC_LVD] = ~state_reg.lvd_s[2] & state_reg.lvd_s[1];

		wakeable = '0;
		wakeable[SRC_ADC] = state_reg.adc_wake;
		wakeable[SRC_CMP] = state_reg.cmp_wake;
		wakeable[SRC_LVD] = state_reg.lvd_wake;
		// Wake only through a wake enable
		wake_ev = (state_reg.mode == MODE_SLEEP)
			& (|(ev & wakeable));

		// Register writes
		if (wr_en) begin
			case (addr)
				ADDR_IRQ_EN: begin
					state_next.en = to_src(wr_data, state_reg.en[SRC_LVD]);
				end
				ADDR_IRQ_FLG: begin
					// Writing 0 clears a flag, writing 1 keeps it
					state_next.flag = state_reg.flag
						& to_src(wr_data, 1'b1);
				end
				ADDR_WAKE: begin
					state_next.cmp_wake = wr_data[WBIT_CMP];
					state_next.adc_wake = wr_data[WBIT_ADC];
					state_next.wdt_en = wr_data[WBIT_WDT];
				end
				ADDR_LVD: begin
					state_next.lvd_wake = wr_data[LBIT_WAKE];
					state_next.en[SRC_LVD] = wr_data[LBIT_IE];
					state_next.flag[SRC_LVD] = state_reg.flag[SRC_LVD]
						& wr_data[LBIT_FLAG];
				end
				ADDR_ADC: begin
					state_next.adc_run = wr_data[ABIT_RUN];
				end
				default: begin
				end
			endcase
		end

		// Enabled events set flags; set beats a same-cycle clear
		state_next.flag = state_next.flag | (ev & state_reg.en);

		if (ev[SRC_ADC])
			state_next.adc_run = 1'b0;

		// Sleep entry: converter without wake enable is stopped
		if (sleep_req && state_reg.mode == MODE_RUN) begin
			state_next.mode = MODE_SLEEP;
			if (!state_reg.adc_wake && state_reg.adc_run) begin
				state_next.adc_run = 1'b0;
				if (state_reg.en[SRC_ADC])
					state_next.flag[SRC_ADC] = 1'b1;
			end
		end

		state_next.wake = wake_ev;
		if (wake_ev)
			state_next.mode = MODE_RUN;

		if (global_irq_enable_instr)
			state_next.gie = 1'b1;
		if (global_irq_disable_instr)
			state_next.gie = 1'b0;

		if (irq_ack)
			state_next.irq_req = 1'b0;

		// Dispatch only once awake, so a wake-up resumes the
		// instruction stream unless the global enable is on
		pend = state_reg.flag & state_reg.en;
		if (!state_reg.irq_req && state_reg.gie
				&& state_reg.mode == MODE_RUN && |pend) begin
			state_next.irq_req = 1'b1;
			state_next.vec = pick_vec(pend);
			state_next.gie = 1'b0;
		end

		// Watchdog overrides mode, request, vector and global enable; if asleep, wake pulses in the same cycle as the reset
		state_next.wdt_rst = 1'b0;
		if (wdt_timeout && state_reg.wdt_en) begin
			state_next.wdt_rst = 1'b1;
			state_next.wake = state_reg.mode == MODE_SLEEP;
			state_next.mode = MODE_RUN;
			state_next.irq_req = 1'b0;
			state_next.vec = VEC_RESET;
			state_next.gie = 1'b0;
		end

		// Clocks stop in sleep unless a waking conversion runs
		state_next.osc = (state_next.mode == MODE_RUN)
			| (state_next.adc_wake & state_next.adc_run);

		state_next.rd = RST_BYTE;
		if (rd_en) begin
			case (addr)
				ADDR_IRQ_EN:
					state_next.rd = to_byte(state_reg.en);
				ADDR_IRQ_FLG:
					state_next.rd = to_byte(state_reg.flag);
				ADDR_WAKE: begin
					state_next.rd[WBIT_CMP] = state_reg.cmp_wake;
					state_next.rd[WBIT_ADC] = state_reg.adc_wake;
					state_next.rd[WBIT_WDT] = state_reg.wdt_en;
				end
				ADDR_LVD: begin
					state_next.rd[LBIT_WAKE] = state_reg.lvd_wake;
					state_next.rd[LBIT_IE] = state_reg.en[SRC_LVD];
					state_next.rd[LBIT_FLAG] = state_reg.flag[SRC_LVD];
				end
				ADDR_ADC:
					state_next.rd[ABIT_RUN] = state_reg.adc_run;
				ADDR_STATUS: begin
					state_next.rd[SBIT_GIE] = state_reg.gie;
					state_next.rd[SBIT_SLEEP] =
						state_reg.mode == MODE_SLEEP;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data     = state_reg.rd;
	assign irq_req     = state_reg.irq_req;
	assign irq_vector  = state_reg.vec;
	assign wake_pulse  = state_reg.wake;
	assign asleep      = state_reg.mode == MODE_SLEEP;
	assign osc_run     = state_reg.osc;
	assign adc_running = state_reg.adc_run;
	assign wdt_reset   = state_reg.wdt_rst;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	chk_ext_flag_set: assert property (
		ev[SRC_EXT] && state_reg.en[SRC_EXT]
			|=> state_reg.flag[SRC_EXT])
		else $error("ext pin event did not set its flag");

	chk_vector_needs_gie: assert property (
		$rose(irq_req) |-> $past(state_reg.gie)
			&& !state_reg.gie)
		else $error("vector taken without global enable");

	chk_adc_sleep_stop: assert property (
		sleep_req && !asleep && !state_reg.adc_wake
			&& !(wr_en && addr == ADDR_ADC)
			|=> !adc_running)
		else $error("converter kept running into sleep");

	chk_sleep_clock_stop: assert property (
		osc_run && asleep |-> state_reg.adc_wake && adc_running)
		else $error("clocks running in sleep without ADC wake");

	chk_cmp_wake: assert property (
		asleep && ev[SRC_CMP] && state_reg.cmp_wake
			|=> wake_pulse && !asleep)
		else $error("comparator change did not wake");

	chk_wake_from_sleep: assert property (
		wake_pulse |-> $past(asleep) && !asleep)
		else $error("wake pulse without prior sleep");

	chk_wdt_reset: assert property (
		wdt_timeout && state_reg.wdt_en |=> wdt_reset
			&& !asleep && !irq_req && irq_vector == VEC_RESET)
		else $error("watchdog timeout did not reset");

	chk_irq_from_flag: assert property (
		$rose(irq_req) |-> irq_vector == pick_vec($past(pend))
			&& $past(pend) != '0)
		else $error("vector not from highest pending flag");

	chk_no_irq_asleep: assert property (
		$rose(irq_req) |-> !$past(asleep))
		else $error("interrupt dispatched while asleep");

	// Every wake enable off, so nothing may end the sleep
	chk_cmp_no_wake: assert property (
		asleep && ev[SRC_CMP] && !state_reg.cmp_wake
			&& !state_reg.adc_wake && !state_reg.lvd_wake
			&& !state_reg.wdt_en
			|=> asleep && !wake_pulse)
		else $error("comparator woke without its wake enable");

	chk_pwm_no_wake: assert property (
		asleep && pwm_match != '0 && !wr_en
			&& !state_reg.adc_wake && !state_reg.cmp_wake
			&& !state_reg.lvd_wake && !state_reg.wdt_en
			|=> asleep && $stable(state_reg.flag[SRC_PWM1+:3]))
		else $error("period match acted during sleep");

	// Software writes can only clear, so a clear flag stays clear
	chk_lvd_no_flag: assert property (
		ev[SRC_LVD] && !state_reg.en[SRC_LVD]
			&& !state_reg.flag[SRC_LVD]
			|=> !state_reg.flag[SRC_LVD])
		else $error("detector set its flag while disabled");

endmodule : wakeup_interrupt_dispatch

// file: sim/core_model.sv
// Core model: takes a raised interrupt after a short delay.
// Assumes irq_req stays up until irq_ack is seen at a clock edge.
`timescale 1ns/1ps
module core_model
	import wakeup_irq_pkg::*;
#(
	parameter int ACK_DLY = 3
)(
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic irq_req,
	output logic      irq_ack
);
	int cnt;
	// Slow on purpose, so the request must stand
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			irq_ack <= 1'b0;
		end else begin
			irq_ack <= 1'b0;
			if (irq_req && !irq_ack) begin
				cnt <= cnt + 1;
				if (cnt == ACK_DLY) begin
					irq_ack <= 1'b1;
					cnt <= 0;
				end
			end
		end
	end
endmodule : core_model

// file: sim/wakeup_interrupt_dispatch_test.sv
// Bench for the wake-up and interrupt dispatch block.
// Assumes core_model answers irq_req; events driven here.
`timescale 1ns/1ps
module wakeup_interrupt_dispatch_test;
	import wakeup_irq_pkg::*;
	logic          sys_clk = 0, resetn = 0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wr_data = '0, v;
	logic          wr_en = 0, rd_en = 0, irq_ack, irq_req;
	logic          ext_pin = 1, cmp_out = 0, low_volt = 0;
	logic [7:0]    pls = '0;
	logic [DW-1:0] rd_data, irq_vector;
	logic          wake_pulse, asleep, osc_run, adc_running, wdt_reset;
	int            n_errors = 0, compares = 0;
	// Pulse masks for the same-clock event inputs
	localparam logic [7:0] P_ADC = 8'h01, P_SLP = 8'h02, P_ENI = 8'h04;
	localparam logic [7:0] P_WDT = 8'h10, P_PWM = 8'h20, P_DIS = 8'h08;
	wakeup_interrupt_dispatch dut (.sys_clk(sys_clk), .resetn(resetn),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .ext_pin(ext_pin), .cmp_out(cmp_out),
		.low_volt_detect(low_volt), .adc_done(pls[0]),
		.pwm_match(pls[7:5]), .wdt_timeout(pls[4]), .sleep_req(pls[1]),
		.global_irq_enable_instr(pls[2]),
		.global_irq_disable_instr(pls[3]), .irq_ack(irq_ack),
		.irq_req(irq_req), .irq_vector(irq_vector),
		.wake_pulse(wake_pulse), .asleep(asleep), .osc_run(osc_run),
		.adc_running(adc_running), .wdt_reset(wdt_reset));
	core_model core (.sys_clk(sys_clk), .resetn(resetn),
		.irq_req(irq_req), .irq_ack(irq_ack));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge sys_clk) {addr, wr_data, wr_en} <= {a, d, 1'b1};
		@(posedge sys_clk) wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [AW-1:0] a);
		@(posedge sys_clk) {addr, rd_en} <= {a, 1'b1};
		@(posedge sys_clk) rd_en <= 1'b0;
		#1 v = rd_data;
	endtask : rd
	task pulse(input logic [7:0] m);
		@(posedge sys_clk) pls <= m;
		@(posedge sys_clk) pls <= '0;
	endtask : pulse
	// Bounded wait for a request, then for its withdrawal after ack
	task wait_vec(input logic [DW-1:0] e);
		for (int i = 0; i < 30 && irq_req !== 1'b1; i++) tick(1);
		// A request that never came must not pass on a stale vector
		chk(irq_req === 1'b1 ? irq_vector : ~e, e);
		for (int i = 0; i < 30 && irq_req !== 1'b0; i++) tick(1);
		wr(ADDR_IRQ_FLG, 8'h00);
	endtask : wait_vec
	task report_and_stop;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		#50000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		tick(4);
		// Unmapped places read zero, also after a write
		wr(3'h6, 8'hFF);
		for (int a = 0; a < 8; a++) begin
			rd(a[AW-1:0]);
			chk(v, RST_BYTE);
		end
		wr(ADDR_IRQ_EN, 8'h04);
		@(posedge sys_clk) ext_pin <= 1'b0;
		tick(6);
		chk(irq_req, 1'b0);
		rd(ADDR_IRQ_FLG);
		chk(v, 8'h04);
		wr(ADDR_IRQ_FLG, 8'h00);
		@(posedge sys_clk) ext_pin <= 1'b1;
		tick(4);
		pulse(P_ENI);
		@(posedge sys_clk) ext_pin <= 1'b0;
		wait_vec(VEC_EXT);
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_IRQ_EN, 8'h10 << c);
			pulse(P_PWM << c);
			tick(3);
			rd(ADDR_IRQ_FLG);
			chk(v, 8'h10 << c);
			pulse(P_ENI);
			wait_vec(VEC_PWM1 + 8'(3 * c));
		end
		// Converter done with its enable cleared
		wr(ADDR_IRQ_EN, 8'h00);
		wr(ADDR_ADC, 8'h01);
		pulse(P_ENI);
		pulse(P_ADC);
		tick(4);
		chk(irq_req, 1'b0);
		wr(ADDR_IRQ_EN, 8'h08);
		wr(ADDR_ADC, 8'h01);
		pulse(P_ADC);
		wait_vec(VEC_ADC);
		chk(adc_running, 1'b0);
		// Sleep with converter running and no ADC enables
		wr(ADDR_IRQ_EN, 8'h00);
		wr(ADDR_ADC, 8'h01);
		wr(ADDR_WAKE, 8'h00);
		pulse(P_SLP);
		tick(2);
		chk({asleep, osc_run, adc_running}, 8'h04);
		wr(ADDR_WAKE, 8'h80);
		pulse(P_WDT);
		#1;
		chk({5'h00, wdt_reset, asleep, wake_pulse}, 8'h05);
		chk(irq_vector, VEC_RESET);
		wr(ADDR_WAKE, 8'h08);
		wr(ADDR_IRQ_EN, 8'h08);
		wr(ADDR_ADC, 8'h01);
		pulse(P_ENI);
		pulse(P_SLP);
		tick(2);
		chk({asleep, osc_run}, 8'h03);
		pulse(P_ADC);
		wait_vec(VEC_ADC);
		chk(asleep, 1'b0);
		// Converter wakes with global disabled: flag, no vector
		wr(ADDR_ADC, 8'h01);
		pulse(P_ENI);
		rd(ADDR_STATUS);
		chk(v, 8'h01);
		pulse(P_DIS);
		pulse(P_SLP);
		rd(ADDR_STATUS);
		chk(v, 8'h02);
		pulse(P_ADC);
		#1;
		chk({6'h00, asleep, wake_pulse}, 8'h01);
		tick(4);
		chk(irq_req, 1'b0);
		rd(ADDR_IRQ_FLG);
		chk(v, 8'h08);
		wr(ADDR_IRQ_FLG, 8'h00);
		// Comparator asleep: flag only, clocks held
		wr(ADDR_WAKE, 8'h00);
		wr(ADDR_IRQ_EN, 8'h90);
		pulse(P_SLP);
		pulse(P_PWM);
		@(posedge sys_clk) cmp_out <= ~cmp_out;
		tick(6);
		chk({asleep, osc_run}, 8'h02);
		rd(ADDR_IRQ_FLG);
		chk(v, 8'h80);
		wr(ADDR_IRQ_FLG, 8'h00);
		wr(ADDR_WAKE, 8'h04);
		pulse(P_ENI);
		@(posedge sys_clk) cmp_out <= ~cmp_out;
		wait_vec(VEC_PWM1);
		chk(asleep, 1'b0);
		// Detector wakes and vectors
		wr(ADDR_IRQ_EN, 8'h00);
		wr(ADDR_WAKE, 8'h00);
		wr(ADDR_LVD, 8'h18);
		pulse(P_ENI);
		pulse(P_SLP);
		@(posedge sys_clk) low_volt <= 1'b1;
		wait_vec(VEC_LVD);
		rd(ADDR_LVD);
		chk(v, 8'h38);
		wr(ADDR_LVD, 8'h00);
		@(posedge sys_clk) low_volt <= 1'b0;
		pulse(P_SLP);
		@(posedge sys_clk) low_volt <= 1'b1;
		tick(6);
		chk({asleep, irq_req}, 8'h02);
		rd(ADDR_LVD);
		chk(v, 8'h00);
		report_and_stop;
	end
endmodule : wakeup_interrupt_dispatch_test
